// ### bench/owl_dbg_model.sv
`timescale 1ns/1ps
`default_nettype none
// Debugger model: it only pulls the wire low, so the pull-up gives the high level.
module owl_dbg_model (
    input wire logic clk,
    input wire logic line,
    output logic drv_low
);
    // The debugger is master; the device sends only when the bench raises tx_req or grants the bus, not on this model's frames.
    // Bit length in clocks; exact and within the recommended rate.
    int bit_clk = 32;
    initial drv_low = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Sends twelve bit times LSB first, then releases the line for two idle bits.
    task automatic send_bits(input logic [11:0] b);
        for (int i = 0; i < 14; i++) begin
            drv_low <= (i < 12) ? ~b[i] : 1'b0;
            repeat (bit_clk) @(posedge clk);
        end
    endtask
    // Sends one data frame, optionally with a flipped parity or a low first stop.
    task automatic send_byte(input logic [7:0] d, input logic pflip, input logic sbad);
        send_bits({1'b1, ~sbad, ^d ^ pflip, d, 1'b0});
    endtask
    // Waits for a start bit and samples each of the twelve bits mid-way.
    task automatic recv(output logic [11:0] f);
        int n;
        n = 0;
        while (line !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        repeat (bit_clk / 2) @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            f[i] = line;
            repeat (bit_clk) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ### bench/test_one_wire_debug_uart_phy.sv
`timescale 1ns/1ps
`default_nettype none
module test_one_wire_debug_uart_phy;
    import owl_pkg::*;
    logic clk, rstn, link_en, pcd, clksel_wr, sync_expect, tx_req, store_req;
    logic cpu_stop, bus_gnt, pin_o_q, pin_oe_q, pin_pue_q, pin_ie_q, drv_low;
    logic rx_valid_q, rx_err_q, brk_q, tx_ready_q, bus_req_q;
    logic [1:0] clksel_data, phy_clk_sel_q;
    logic [7:0] rx_data_q, tx_data;
    logic [11:0] f;
    int n_mismatch, n_checks, n_val, n_err, n_brk;
    // The wire: device drive wins, then the debugger's pull-down, then the pull-up.
    wire line = pin_oe_q ? pin_o_q : (drv_low ? 1'b0 : 1'b1);
    owl_phy dut_u (.clk(clk), .rstn(rstn), .link_en(link_en), .pin_i(line),
        .pin_o_q(pin_o_q), .pin_oe_q(pin_oe_q), .pin_pue_q(pin_pue_q), .pin_ie_q(pin_ie_q),
        .parity_check_disable(pcd), .clksel_wr(clksel_wr), .clksel_data(clksel_data),
        .phy_clk_sel_q(phy_clk_sel_q), .sync_expect(sync_expect), .rx_data_q(rx_data_q),
        .rx_valid_q(rx_valid_q), .rx_err_q(rx_err_q), .brk_q(brk_q), .tx_req(tx_req),
        .tx_data(tx_data), .tx_ready_q(tx_ready_q), .store_req(store_req),
        .cpu_clk_stopped(cpu_stop), .bus_req_q(bus_req_q), .bus_gnt(bus_gnt));
    owl_dbg_model dbg_u (.clk(clk), .line(line), .drv_low(drv_low));
    ////////////////////////////////////////////////////////////////////////
    // Clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Counts the one-cycle receive pulses.
    always @(posedge clk) begin
        if (rx_valid_q === 1'b1) n_val++;
        if (rx_err_q === 1'b1) n_err++;
        if (brk_q === 1'b1) n_brk++;
    end
    ////////////////////////////////////////////////////////////////////////
    // Compares a seen value with the expected one.
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic final_report;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Clears the pulse counters.
    task automatic clr;
        n_val = 0;
        n_err = 0;
        n_brk = 0;
    endtask
    // Sends a sync character at the given bit length.
    task automatic t_sync(input int bc);
        dbg_u.bit_clk = bc;
        clr();
        dbg_u.send_byte(8'h55, 1'b0, 1'b0);
        check(12'(n_err), 12'h000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Pin state after reset with the link enabled.
    task automatic t_reset;
        check({pin_o_q, pin_oe_q, pin_pue_q, pin_ie_q}, 12'h00B);
        check(12'(phy_clk_sel_q), 12'(CLKSEL_RST));
    endtask
    // Received bytes, all with a zero parity bit, then a quiet idle stretch.
    task automatic t_rx;
        logic [7:0] v[3] = '{8'h00, 8'hFF, 8'hA3};
        for (int i = 0; i < 3; i++) begin
            clr();
            dbg_u.send_byte(v[i], 1'b0, 1'b0);
            check({4'h0, rx_data_q}, {4'h0, v[i]});
            check(12'(n_val), 12'h001);
        end
        clr();
        repeat (12 * dbg_u.bit_clk) @(posedge clk);
        check(12'(n_val + n_err + n_brk), 12'h000);
    endtask
    // Parity skip, parity and stop faults, error lock-out and break recovery.
    task automatic t_errors;
        clr();
        pcd <= 1'b1;
        dbg_u.send_byte(8'h5A, 1'b1, 1'b0);
        check(12'(n_val), 12'h001);
        pcd <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            clr();
            dbg_u.send_byte(8'h5A, k == 0, k == 1);
            check(12'(n_err), 12'h001);
            dbg_u.send_byte(8'h11, 1'b0, 1'b0);
            check(12'(n_val + n_err), 12'h001);
            dbg_u.send_bits(12'h000);
            check(12'(n_brk), 12'h001);
            t_sync(32);
        end
    endtask
    // Every clock select code, an ignored zero, then a double break.
    task automatic t_clksel;
        logic [1:0] c[4] = '{CLKSEL_16M, CLKSEL_8M, CLKSEL_4M, CLKSEL_16M};
        for (int i = 0; i < 5; i++) begin
            clksel_data <= (i < 4) ? c[i] : 2'h0;
            clksel_wr <= 1'b1;
            @(posedge clk);
            clksel_wr <= 1'b0;
            repeat (2) @(posedge clk);
            check(12'(phy_clk_sel_q), 12'(c[(i < 4) ? i : 3]));
        end
        clr();
        dbg_u.send_bits(12'h000);
        dbg_u.send_bits(12'h000);
        check(12'(n_brk), 12'h002);
        check(12'(phy_clk_sel_q), 12'(CLKSEL_4M));
        t_sync(32);
    endtask
    // Requests a transmit and holds it until tx_ready_q is seen high.
    task automatic t_send(input logic [7:0] d);
        int n;
        tx_data <= d;
        tx_req <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tx_ready_q !== 1'b1 && n < 200);
        tx_req <= 1'b0;
    endtask
    // A new sync at another rate, then a byte sent back at that rate.
    task automatic t_tx;
        sync_expect <= 1'b1;
        @(posedge clk);
        sync_expect <= 1'b0;
        t_sync(48);
        fork
            t_send(8'h96);
            dbg_u.recv(f);
        join
        check(f, {2'b11, ^8'h96, 8'h96, 1'b0});
        check({11'h000, pin_oe_q}, 12'h000);
    endtask
    // Store grant yields an acknowledge; a stopped cpu clock withholds the bus.
    task automatic t_ack;
        store_req <= 1'b1;
        @(posedge clk);
        store_req <= 1'b0;
        repeat (2) @(posedge clk);
        check({11'h000, bus_req_q}, 12'h001);
        fork
            begin
                bus_gnt <= 1'b1;
                @(posedge clk);
                bus_gnt <= 1'b0;
            end
            dbg_u.recv(f);
        join
        check(f, {2'b11, ^ACK_CHAR, ACK_CHAR, 1'b0});
        cpu_stop <= 1'b1;
        repeat (4) @(posedge clk);
        store_req <= 1'b1;
        @(posedge clk);
        store_req <= 1'b0;
        repeat (5) @(posedge clk);
        check({11'h000, bus_req_q}, 12'h000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {rstn, pcd, clksel_wr, sync_expect, tx_req, store_req, cpu_stop, bus_gnt} = '0;
        link_en = 1'b1;
        clksel_data = 2'h0;
        tx_data = 8'h00;
        n_mismatch = 0;
        n_checks = 0;
        clr();
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_sync(32);
        t_rx();
        t_errors();
        t_clksel();
        t_tx();
        t_ack();
        final_report();
    end
    // Watchdog against a hang.
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire

// ### verilog/owl_phy.sv
`timescale 1ns/1ps
`default_nettype none
module owl_phy
    import owl_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic link_en,
    input wire logic pin_i,
    output logic pin_o_q,
    output logic pin_oe_q,
    output logic pin_pue_q,
    output logic pin_ie_q,
    input wire logic parity_check_disable,
    input wire logic clksel_wr,
    input wire logic [1:0] clksel_data,
    output logic [1:0] phy_clk_sel_q,
    input wire logic sync_expect,
    output logic [7:0] rx_data_q,
    output logic rx_valid_q,
    output logic rx_err_q,
    output logic brk_q,
    input wire logic tx_req,
    input wire logic [7:0] tx_data,
    output logic tx_ready_q,
    input wire logic store_req,
    input wire logic cpu_clk_stopped,
    output logic bus_req_q,
    input wire logic bus_gnt
);
    owl_state_t state_q;
    logic [1:0] sync_s;
    logic line_s;
    logic cpu_stop_s;
    logic line_prev_q;
    logic fall;
    logic [BAUD_W-1:0] baud_q;
    logic [BAUD_W-1:0] acc_q;
    logic [BAUD_W-1:0] acc_sum;
    logic tick;
    logic [BAUD_W-1:0] meas_q;
    logic [2:0] edges_q;
    logic sync_done_q;
    logic sync_bad;
    logic rx_busy_q;
    logic rx_start;
    logic [3:0] samp_q;
    logic [3:0] bitn_q;
    logic [1:0] votes_q;
    logic [11:0] rx_sh_q;
    logic bit_val;
    logic bit_end;
    logic fr_done;
    logic [11:0] fr;
    logic fr_brk;
    logic fr_err;
    logic [11:0] tx_sh_q;
    logic tx_take;
    logic ack_pend_q;
    logic ack_go;
    logic tx_go;
    logic tx_done;
    logic [3:0] tx_samp_q;
    logic [3:0] tx_bitn_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisation and edge detect.

    // Pin and CPU clock status pass a two-flop stage before use.
    owl_sync2 #(.WIDTH(2)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_i({cpu_clk_stopped, pin_i}),
        .sync_o(sync_s)
    );
    assign line_s = sync_s[0];
    assign cpu_stop_s = sync_s[1];

    // Previous line level for falling edge detection.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_prev_q <= 1'b1;
        end else begin
            line_prev_q <= line_s;
        end
    end
    assign fall = line_prev_q & ~line_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Fractional sample tick generator, shared by receive and transmit.

    // Adding 128 per clock against eight bit times gives sixteen ticks a bit.
    assign acc_sum = acc_q + OVS_ADD;
    assign tick = (acc_sum >= baud_q);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_q <= '0;
        end else if (rx_start || tx_take || ack_go) begin
            acc_q <= '0;
        end else if (tick) begin
            acc_q <= acc_sum - baud_q;
        end else begin
            acc_q <= acc_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sync character measurement.

    // Too short a period or an overflow counts as a sync error.
    assign sync_bad = (state_q == L_SYNC) && !sync_done_q && (edges_q != 3'h0)
        && ((meas_q == MEAS_MAX) || (fall && edges_q == 3'h4 && meas_q < BAUD_MIN));

    // Count clocks from the first to the fifth falling edge, then store.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meas_q <= '0;
            edges_q <= 3'h0;
            sync_done_q <= 1'b0;
            baud_q <= BAUD_RST;
        end else if (state_q != L_SYNC || !link_en || sync_bad || fr_brk) begin
            meas_q <= '0;
            edges_q <= 3'h0;
            sync_done_q <= 1'b0;
        end else if (!sync_done_q) begin
            if (edges_q != 3'h0) begin
                meas_q <= meas_q + 20'h00001;
            end
            if (fall) begin
                edges_q <= edges_q + 3'h1;
                if (edges_q == SYNC_EDGES - 3'h1) begin
                    baud_q <= meas_q + 20'h00001;
                    sync_done_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame receiver with majority vote.

    // Receiver also listens in sync state until the sync is measured, so a break is heard.
    assign rx_start = fall && !rx_busy_q && state_q != L_TX
        && !(state_q == L_SYNC && sync_done_q);
    // A frame ends at the vote of its last bit, sample 9 of the second stop bit.
    assign bit_end = rx_busy_q && tick && (samp_q == VOTE_C);
    assign bit_val = (votes_q + {1'b0, line_s}) >= 2'h2;
    assign fr_done = bit_end && (bitn_q == LAST_BIT);
    assign fr = {bit_val, rx_sh_q[11:1]};
    assign fr_brk = fr_done && (fr == 12'h000);
    assign fr_err = fr_done && !fr_brk && (fr[0] || !fr[10] || !fr[11]
        || (!parity_check_disable && (^fr[PAR_POS:1])));

    // Votes on samples 7 and 8 are kept; sample 9 joins at the bit end.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_busy_q <= 1'b0;
            samp_q <= 4'h0;
            bitn_q <= 4'h0;
            votes_q <= 2'h0;
            rx_sh_q <= 12'hFFF;
        end else if (!link_en || state_q == L_TX || (state_q == L_SYNC && sync_done_q)) begin
            rx_busy_q <= 1'b0;
        end else if (rx_start) begin
            rx_busy_q <= 1'b1;
            samp_q <= 4'h0;
            bitn_q <= 4'h0;
            votes_q <= 2'h0;
        end else if (rx_busy_q && tick) begin
            samp_q <= samp_q + 4'h1;
            if (samp_q >= VOTE_A && samp_q < VOTE_C) begin
                votes_q <= votes_q + {1'b0, line_s};
            end
            if (samp_q == VOTE_C) begin
                rx_sh_q <= {bit_val, rx_sh_q[11:1]};
                bitn_q <= bitn_q + 4'h1;
                votes_q <= 2'h0;
                if (bitn_q == LAST_BIT) begin
                    rx_busy_q <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link state machine.

    assign ack_go = bus_gnt && bus_req_q && state_q == L_RUN && !rx_busy_q && !rx_start;
    assign tx_take = tx_req && tx_ready_q && state_q == L_RUN && !rx_busy_q && !rx_start
        && !ack_go;
    assign tx_go = ack_go || tx_take;
    assign tx_done = (state_q == L_TX) && tick && (tx_samp_q == LAST_SAMPLE)
        && (tx_bitn_q == LAST_BIT);

    // Break wins from every listening state; an error parks the link.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= L_SYNC;
        end else if (!link_en) begin
            state_q <= L_SYNC;
        end else begin
            case (state_q)
                L_SYNC: begin
                    if (fr_brk) begin
                        state_q <= L_SYNC;
                    end else if (sync_bad) begin
                        state_q <= L_ERR;
                    end else if (sync_done_q && line_s && !line_prev_q) begin
                        state_q <= L_RUN;
                    end
                end
                L_RUN: begin
                    if (fr_brk) begin
                        state_q <= L_SYNC;
                    end else if (fr_err) begin
                        state_q <= L_ERR;
                    end else if (tx_go) begin
                        state_q <= L_TX;
                    end else if (sync_expect && !rx_busy_q && !rx_start) begin
                        state_q <= L_SYNC;
                    end
                end
                L_TX: begin
                    if (tx_done) begin
                        state_q <= L_RUN;
                    end
                end
                default: begin
                    if (fr_brk) begin
                        state_q <= L_SYNC;
                    end
                end
            endcase
        end
    end

    // Received byte, error and break pulses; error state drops data.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_err_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            rx_valid_q <= fr_done && !fr_brk && !fr_err && state_q == L_RUN;
            rx_err_q <= (fr_err && state_q == L_RUN) || sync_bad;
            brk_q <= fr_brk;
            if (fr_done && state_q == L_RUN) begin
                rx_data_q <= fr[8:1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmitter, using the recovered baud and the same frame format.

    // Each bit lasts sixteen ticks of the shared fractional generator.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_sh_q <= 12'hFFF;
            pin_o_q <= 1'b1;
            pin_oe_q <= 1'b0;
        end else if (!link_en || fr_brk) begin
            pin_o_q <= 1'b1;
            pin_oe_q <= 1'b0;
        end else if (ack_go) begin
            tx_sh_q <= {2'b11, ^ACK_CHAR, ACK_CHAR, 1'b0};
            pin_o_q <= 1'b0;
            pin_oe_q <= 1'b1;
        end else if (tx_take) begin
            tx_sh_q <= {2'b11, ^tx_data, tx_data, 1'b0};
            pin_o_q <= 1'b0;
            pin_oe_q <= 1'b1;
        end else if (tx_done) begin
            pin_o_q <= 1'b1;
            pin_oe_q <= 1'b0;
        end else if (state_q == L_TX && tick && tx_samp_q == LAST_SAMPLE) begin
            tx_sh_q <= {1'b1, tx_sh_q[11:1]};
            pin_o_q <= tx_sh_q[1];
        end
    end

    // Transmit bit timing: sixteen ticks a bit, twelve bits a frame.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_samp_q <= 4'h0;
            tx_bitn_q <= 4'h0;
        end else if (tx_go) begin
            tx_samp_q <= 4'h0;
            tx_bitn_q <= 4'h0;
        end else if (state_q == L_TX && tick) begin
            tx_samp_q <= tx_samp_q + 4'h1;
            if (tx_samp_q == LAST_SAMPLE) begin
                tx_bitn_q <= tx_bitn_q + 4'h1;
            end
        end
    end

    // Transmit is ready only in run state with no frame arriving.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_ready_q <= 1'b0;
        end else begin
            tx_ready_q <= link_en && state_q == L_RUN && !rx_busy_q && !rx_start && !tx_go
                && !fr_brk && !fr_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus access request, clock select and pad control.

    // A store waits for the bus; no request while the CPU clock stands.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_pend_q <= 1'b0;
            bus_req_q <= 1'b0;
        end else if (!link_en || fr_brk) begin
            ack_pend_q <= 1'b0;
            bus_req_q <= 1'b0;
        end else begin
            if (store_req) begin
                ack_pend_q <= 1'b1;
            end else if (ack_go) begin
                ack_pend_q <= 1'b0;
            end
            bus_req_q <= (ack_pend_q || store_req) && !ack_go && !cpu_stop_s;
        end
    end

    // Clock select defaults to 4 MHz on enable and on break; zero is ignored.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phy_clk_sel_q <= CLKSEL_RST;
        end else if (!link_en || fr_brk) begin
            phy_clk_sel_q <= CLKSEL_RST;
        end else if (clksel_wr && clksel_data != 2'h0) begin
            phy_clk_sel_q <= clksel_data;
        end
    end

    // Pad enables follow the link, not the general port setup.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_pue_q <= 1'b0;
            pin_ie_q <= 1'b0;
        end else begin
            pin_pue_q <= link_en;
            pin_ie_q <= link_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_tx_drive_state: assert property (pin_oe_q == (state_q == L_TX))
        else $error("output enable does not match transmit state");
    a_tx_start_low: assert property ($rose(pin_oe_q) |-> !pin_o_q)
        else $error("frame did not open with a low start bit");
    a_tx_stop_high: assert property ($fell(pin_oe_q) |-> $past(pin_o_q) && pin_o_q)
        else $error("line released without a high stop bit");
    a_break_clksel: assert property (brk_q && link_en |-> phy_clk_sel_q == CLKSEL_RST)
        else $error("break did not restore default clock select");
    a_break_sync: assert property (fr_brk && link_en |=> state_q == L_SYNC)
        else $error("break did not return link to sync");
    a_err_parks: assert property (rx_err_q && link_en |-> state_q == L_ERR)
        else $error("error did not enter error state");
    a_err_ignore: assert property (state_q == L_ERR && !fr_brk |=> !rx_valid_q)
        else $error("data accepted in error state");
    a_bus_sleep: assert property (cpu_stop_s |=> !bus_req_q)
        else $error("bus requested while CPU clock stopped");
    a_ack_sent: assert property (ack_go |=> pin_oe_q && !pin_o_q ##1 pin_oe_q)
        else $error("acknowledge did not start after bus grant");
    a_sync_store: assert property (state_q == L_SYNC && link_en && !sync_done_q && fall
        && edges_q == 3'h4 && !sync_bad |=> baud_q == $past(meas_q) + 20'h00001)
        else $error("sync period not stored");

    c_break: cover property (brk_q);
    c_ack: cover property (ack_go ##1 pin_oe_q);
    c_rx_byte: cover property (rx_valid_q);
    c_error: cover property (rx_err_q);
endmodule
`default_nettype wire

// ### verilog/owl_pkg.sv
`default_nettype none
package owl_pkg;
    // Frame layout: start, eight data bits, parity, two stops.
    localparam int FRAME_BITS = 12;
    localparam logic [3:0] LAST_BIT = 4'hB;
    localparam logic [3:0] PAR_POS = 4'h9;
    // Oversampling and majority vote sample positions.
    localparam logic [3:0] LAST_SAMPLE = 4'hF;
    localparam logic [3:0] VOTE_A = 4'h7;
    localparam logic [3:0] VOTE_C = 4'h9;
    // Sync character measurement: five falling edges span eight bit times.
    localparam int BAUD_W = 20;
    localparam logic [2:0] SYNC_EDGES = 3'h5;
    localparam logic [BAUD_W-1:0] OVS_ADD = 20'h00080;
    localparam logic [BAUD_W-1:0] BAUD_MIN = 20'h00080;
    localparam logic [BAUD_W-1:0] BAUD_RST = 20'h00800;
    localparam logic [BAUD_W-1:0] MEAS_MAX = 20'hFFFFF;
    // Oscillator select codes.
    localparam logic [1:0] CLKSEL_16M = 2'h1;
    localparam logic [1:0] CLKSEL_8M = 2'h2;
    localparam logic [1:0] CLKSEL_4M = 2'h3;
    localparam logic [1:0] CLKSEL_RST = CLKSEL_4M;
    // Acknowledge character value; the value is arbitrary.
    localparam logic [7:0] ACK_CHAR = 8'h40;
    // Link states, Gray coded along sync, run, transmit.
    typedef enum logic [1:0] {
        L_SYNC = 2'b00,
        L_RUN = 2'b01,
        L_TX = 2'b11,
        L_ERR = 2'b10
    } owl_state_t;
endpackage
`default_nettype wire

// ### verilog/owl_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module owl_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // Two flops; only the second one looks at the first.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '1;
            sync_o <= '1;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire
